//--- core/video_standard_detector_pkg.sv
// Constants, register map and state encoding for the video standard detector
package video_standard_detector_pkg;

  // ****************************************************************
  // Register offsets of the component processor map
  // ****************************************************************
  localparam logic [7:0] OFS_INTERLACE_STATUS  = 8'h12;
  localparam logic [7:0] OFS_MODE_TRIGGER      = 8'h86;
  localparam logic [7:0] OFS_LCF_HIGH          = 8'hA3;
  localparam logic [7:0] OFS_LCF_LOW           = 8'hA4;
  localparam logic [7:0] OFS_VALID_STATUS      = 8'hB1;
  localparam logic [7:0] OFS_BL_LOW            = 8'hB2;
  localparam logic [7:0] OFS_LCVS              = 8'hB3;
  localparam logic [7:0] OFS_FCL_HIGH          = 8'hB8;
  localparam logic [7:0] OFS_FCL_LOW           = 8'hB9;
  localparam logic [7:0] OFS_LOCK_BYPASS       = 8'hF5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_CONT_MODE        = 1;
  localparam int BIT_TRIGGER          = 2;
  localparam int BIT_LOCK_BYPASS      = 1;
  localparam int BIT_VALID            = 7;
  localparam int BIT_INTERLACE_DETECT = 6;
  localparam int BIT_DET_INTERLACE    = 4;
  localparam int BIT_CFG_INTERLACE    = 3;
  localparam int LCVS_LSB             = 3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic RST_CONT_MODE   = 1'b1;
  localparam logic RST_TRIGGER     = 1'b0;
  localparam logic RST_LOCK_BYPASS = 1'b0;
  localparam logic RST_VALID       = 1'b0;
  localparam logic RST_INTERLACE   = 1'b0;

  // ****************************************************************
  // Measurement counts and lock thresholds
  // ****************************************************************
  localparam logic [3:0]  LINES_PER_BLOCK   = 4'h8;
  localparam logic [7:0]  HLOCK_LINES       = 8'h80;
  localparam logic [2:0]  VLOCK_FIELDS      = 3'h4;
  localparam logic [2:0]  SAME_FIELDS       = 3'h4;
  localparam int          FIELD_DIV_BITS    = 8;
  localparam logic [13:0] LINE_THRESHOLD    = 14'h0010;
  localparam logic [10:0] FIELD_THRESHOLD   = 11'h001;
  localparam logic [4:0]  VSYNC_THRESHOLD   = 5'h01;

  // ****************************************************************
  // Measurement sequencer states, Gray coded
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_MEASURE = 2'b01,
    ST_DONE    = 2'b11
  } seq_state_t;

endpackage

//--- core/sync_edge_detect.sv
// Two-flop synchroniser with rising-edge pulse for one sync input
`timescale 1ns/1ps
module sync_edge_detect (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic syncIn,
  output logic      syncLevel,
  output logic      syncRise
);

  logic meta_q;
  logic meta_d;
  logic level_q;
  logic level_d;
  logic prev_q;
  logic prev_d;

  // ****************************************************************
  // Only the second flop reads the first one
  // ****************************************************************
  always_comb
  begin
    meta_d  = syncIn;
    level_d = meta_q;
    prev_d  = level_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      meta_q  <= meta_d;
      level_q <= level_d;
      prev_q  <= prev_d;
    end
  end

  assign syncLevel = level_q;
  assign syncRise  = level_q & ~prev_q;

endmodule

//--- core/video_standard_detector.sv
// Sync channel standard detector: measurements, locking, modes and registers
`timescale 1ns/1ps
module video_standard_detector (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       receiverHsync,
  input  wire logic       receiverVsync,
  input  wire logic       receiverDe,
  input  wire logic       configuredInterlace,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  output logic            processorDe
);

  // ****************************************************************
  // Sync inputs
  // ****************************************************************
  logic hsLevel;
  logic hsRise;
  logic vsLevel;
  logic vsRise;

  sync_edge_detect hsyncSync (
    .clk       (clk),
    .srst      (srst),
    .syncIn    (receiverHsync),
    .syncLevel (hsLevel),
    .syncRise  (hsRise)
  );

  sync_edge_detect vsyncSync (
    .clk       (clk),
    .srst      (srst),
    .syncIn    (receiverVsync),
    .syncLevel (vsLevel),
    .syncRise  (vsRise)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  video_standard_detector_pkg::seq_state_t state_q, state_d;

  logic        contMode_q,     contMode_d;
  logic        trigger_q,      trigger_d;
  logic        trigPrev_q,     trigPrev_d;
  logic        bypass_q,       bypass_d;
  logic        cfgIntl_q,      cfgIntl_d;
  logic        de_q,           de_d;
  logic [7:0]  rdData_q,       rdData_d;

  logic [13:0] lineClk_q,      lineClk_d;
  logic [13:0] prevLine_q,     prevLine_d;
  logic [13:0] blockClk_q,     blockClk_d;
  logic [3:0]  blockLines_q,   blockLines_d;
  logic [13:0] blMeas_q,       blMeas_d;
  logic [10:0] fieldLines_q,   fieldLines_d;
  logic [4:0]  vsLines_q,      vsLines_d;
  logic [20:0] fieldClk_q,     fieldClk_d;
  logic [10:0] prevLcf_q,      prevLcf_d;
  logic [4:0]  prevLcvs_q,     prevLcvs_d;
  logic [12:0] prevFcl_q,      prevFcl_d;
  logic        intlMeas_q,     intlMeas_d;

  logic        hLock_q,        hLock_d;
  logic [7:0]  hCnt_q,         hCnt_d;
  logic        vLock_q,        vLock_d;
  logic [2:0]  vCnt_q,         vCnt_d;
  logic [2:0]  sameCnt_q,      sameCnt_d;

  logic [13:0] blRd_q,         blRd_d;
  logic [10:0] lcfRd_q,        lcfRd_d;
  logic [4:0]  lcvsRd_q,       lcvsRd_d;
  logic [12:0] fclRd_q,        fclRd_d;
  logic        intlRd_q,       intlRd_d;
  logic        valid_q,        valid_d;

  function automatic logic [13:0] absDiff14(input logic [13:0] a, input logic [13:0] b);
    absDiff14 = (a > b) ? (a - b) : (b - a);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic        trigRise;
    logic        run;
    logic [13:0] lineLen;
    logic        lineOk;
    logic [10:0] lcfNew;
    logic [4:0]  lcvsNew;
    logic [12:0] fclNew;
    logic        fieldOk;
    logic        measureOk;
    logic        updateNow;
    trigRise   = 1'b0;
    run        = 1'b0;
    lineLen    = 14'h0000;
    lineOk     = 1'b0;
    lcfNew     = 11'h000;
    lcvsNew    = 5'h00;
    fclNew     = 13'h0000;
    fieldOk    = 1'b0;
    measureOk  = 1'b0;
    updateNow  = 1'b0;

    state_d      = state_q;
    contMode_d   = contMode_q;
    trigger_d    = trigger_q;
    trigPrev_d   = trigger_q;
    bypass_d     = bypass_q;
    cfgIntl_d    = configuredInterlace;
    de_d         = receiverDe;
    lineClk_d    = lineClk_q;
    prevLine_d   = prevLine_q;
    blockClk_d   = blockClk_q;
    blockLines_d = blockLines_q;
    blMeas_d     = blMeas_q;
    fieldLines_d = fieldLines_q;
    vsLines_d    = vsLines_q;
    fieldClk_d   = fieldClk_q;
    prevLcf_d    = prevLcf_q;
    prevLcvs_d   = prevLcvs_q;
    prevFcl_d    = prevFcl_q;
    intlMeas_d   = intlMeas_q;
    hLock_d      = hLock_q;
    hCnt_d       = hCnt_q;
    vLock_d      = vLock_q;
    vCnt_d       = vCnt_q;
    sameCnt_d    = sameCnt_q;
    blRd_d       = blRd_q;
    lcfRd_d      = lcfRd_q;
    lcvsRd_d     = lcvsRd_q;
    fclRd_d      = fclRd_q;
    intlRd_d     = intlRd_q;
    valid_d      = valid_q;

    // Control writes; the trigger bit stays as written
    if (regWrEn && regAddr == video_standard_detector_pkg::OFS_MODE_TRIGGER)
    begin
      contMode_d = regWrData[video_standard_detector_pkg::BIT_CONT_MODE];
      trigger_d  = regWrData[video_standard_detector_pkg::BIT_TRIGGER];
    end
    if (regWrEn && regAddr == video_standard_detector_pkg::OFS_LOCK_BYPASS)
    begin
      bypass_d = regWrData[video_standard_detector_pkg::BIT_LOCK_BYPASS];
    end

    // Only a 0 to 1 step acts; a write back to 0 changes nothing else
    trigRise = trigger_q & ~trigPrev_q;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    case (state_q)
      video_standard_detector_pkg::ST_IDLE:
      begin
        if (contMode_q)
          state_d = video_standard_detector_pkg::ST_MEASURE;
      end
      video_standard_detector_pkg::ST_MEASURE:
      begin
        run = 1'b1;
      end
      video_standard_detector_pkg::ST_DONE:
      begin
        if (contMode_q)
          state_d = video_standard_detector_pkg::ST_MEASURE;
      end
      default:
      begin
        state_d = video_standard_detector_pkg::ST_IDLE;
      end
    endcase

    if (!contMode_q && state_q == video_standard_detector_pkg::ST_MEASURE && trigRise)
      run = 1'b0;

    if (!contMode_q && trigRise)
    begin
      // Clear counters, locks and valid; last line and field references are kept and old results stay readable
      state_d      = video_standard_detector_pkg::ST_MEASURE;
      lineClk_d    = 14'h0000;
      blockClk_d   = 14'h0000;
      blockLines_d = 4'h0;
      fieldLines_d = 11'h000;
      vsLines_d    = 5'h00;
      fieldClk_d   = 21'h000000;
      hLock_d      = 1'b0;
      hCnt_d       = 8'h00;
      vLock_d      = 1'b0;
      vCnt_d       = 3'h0;
      sameCnt_d    = 3'h0;
      valid_d      = 1'b0;
    end
    else if (run)
    begin
      // ****************************************************************
      // Horizontal measurement and lock
      // ****************************************************************
      if (lineClk_q != 14'h3FFF)
        lineClk_d = lineClk_q + 14'h0001;
      if (blockClk_q != 14'h3FFF)
        blockClk_d = blockClk_q + 14'h0001;
      if (hsRise)
      begin
        lineLen    = lineClk_q;
        lineOk     = absDiff14(lineLen, prevLine_q) <= video_standard_detector_pkg::LINE_THRESHOLD;
        prevLine_d = lineLen;
        lineClk_d  = 14'h0000;
        if (blockLines_q == video_standard_detector_pkg::LINES_PER_BLOCK - 4'h1)
        begin
          blMeas_d     = blockClk_q;
          blockClk_d   = 14'h0001;
          blockLines_d = 4'h0;
        end
        else
          blockLines_d = blockLines_q + 4'h1;
        if (fieldLines_q != 11'h7FF)
          fieldLines_d = fieldLines_q + 11'h001;
        if (vsLevel && vsLines_q != 5'h1F)
          vsLines_d = vsLines_q + 5'h01;
        // Count runs of agreeing or disagreeing lines against the lock state
        if (hLock_q != lineOk)
        begin
          if (hCnt_q == video_standard_detector_pkg::HLOCK_LINES - 8'h01)
          begin
            hLock_d = lineOk;
            hCnt_d  = 8'h00;
          end
          else
            hCnt_d = hCnt_q + 8'h01;
        end
        else
          hCnt_d = 8'h00;
      end

      // ****************************************************************
      // Vertical measurement and lock
      // ****************************************************************
      if (fieldClk_q != 21'h1FFFFF)
        fieldClk_d = fieldClk_q + 21'h000001;
      if (vsRise)
      begin
        lcfNew  = fieldLines_q;
        lcvsNew = vsLines_q;
        fclNew  = fieldClk_q[20:video_standard_detector_pkg::FIELD_DIV_BITS];
        fieldOk = (absDiff14({3'b000, lcfNew}, {3'b000, prevLcf_q}) <=
                   {3'b000, video_standard_detector_pkg::FIELD_THRESHOLD}) &&
                  (absDiff14({9'h000, lcvsNew}, {9'h000, prevLcvs_q}) <=
                   {9'h000, video_standard_detector_pkg::VSYNC_THRESHOLD});
        // Alternating line counts mean two fields per frame
        intlMeas_d   = (lcfNew != prevLcf_q);
        prevLcf_d    = lcfNew;
        prevLcvs_d   = lcvsNew;
        prevFcl_d    = fclNew;
        fieldLines_d = 11'h000;
        vsLines_d    = 5'h00;
        fieldClk_d   = 21'h000001;
        if (vLock_q != fieldOk)
        begin
          if (vCnt_q == video_standard_detector_pkg::VLOCK_FIELDS - 3'h1)
          begin
            vLock_d = fieldOk;
            vCnt_d  = 3'h0;
          end
          else
            vCnt_d = vCnt_q + 3'h1;
        end
        else
          vCnt_d = 3'h0;
        if (fclNew == prevFcl_q)
        begin
          if (sameCnt_q != video_standard_detector_pkg::SAME_FIELDS)
            sameCnt_d = sameCnt_q + 3'h1;
        end
        else
          sameCnt_d = 3'h0;

        measureOk = hLock_d && vLock_d &&
                    (sameCnt_d == video_standard_detector_pkg::SAME_FIELDS);
        updateNow = bypass_q || measureOk;
        if (updateNow)
        begin
          // All readbacks move together so valid covers one consistent set
          blRd_d   = blMeas_q;
          lcfRd_d  = lcfNew;
          lcvsRd_d = lcvsNew;
          fclRd_d  = fclNew;
          intlRd_d = intlMeas_d;
        end
        valid_d = measureOk;
        if (!contMode_q && measureOk)
          state_d = video_standard_detector_pkg::ST_DONE;
      end
      else if (contMode_q && !(hLock_q && vLock_q))
        valid_d = 1'b0;
    end
    else if (contMode_q != contMode_d && !contMode_d)
      state_d = video_standard_detector_pkg::ST_IDLE;

    if (contMode_q && !contMode_d)
      state_d = video_standard_detector_pkg::ST_IDLE;

    // ****************************************************************
    // Register read; results and settings, no setting is changed by them
    // ****************************************************************
    rdData_d = rdData_q;
    if (regRdEn)
    begin
      case (regAddr)
        video_standard_detector_pkg::OFS_INTERLACE_STATUS:
          rdData_d = {3'b000, intlRd_q, cfgIntl_q, 3'b000};
        video_standard_detector_pkg::OFS_MODE_TRIGGER:
          rdData_d = {5'b00000, trigger_q, contMode_q, 1'b0};
        video_standard_detector_pkg::OFS_LCF_HIGH:
          rdData_d = {5'b00000, lcfRd_q[10:8]};
        video_standard_detector_pkg::OFS_LCF_LOW:
          rdData_d = lcfRd_q[7:0];
        video_standard_detector_pkg::OFS_VALID_STATUS:
          rdData_d = {valid_q, intlRd_q, blRd_q[13:8]};
        video_standard_detector_pkg::OFS_BL_LOW:
          rdData_d = blRd_q[7:0];
        video_standard_detector_pkg::OFS_LCVS:
          rdData_d = {lcvsRd_q, 3'b000};
        video_standard_detector_pkg::OFS_FCL_HIGH:
          rdData_d = {3'b000, fclRd_q[12:8]};
        video_standard_detector_pkg::OFS_FCL_LOW:
          rdData_d = fclRd_q[7:0];
        video_standard_detector_pkg::OFS_LOCK_BYPASS:
          rdData_d = {6'b000000, bypass_q, 1'b0};
        default:
          rdData_d = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q      <= video_standard_detector_pkg::ST_IDLE;
      contMode_q   <= video_standard_detector_pkg::RST_CONT_MODE;
      trigger_q    <= video_standard_detector_pkg::RST_TRIGGER;
      trigPrev_q   <= video_standard_detector_pkg::RST_TRIGGER;
      bypass_q     <= video_standard_detector_pkg::RST_LOCK_BYPASS;
      cfgIntl_q    <= video_standard_detector_pkg::RST_INTERLACE;
      de_q         <= 1'b0;
      rdData_q     <= 8'h00;
      lineClk_q    <= 14'h0000;
      prevLine_q   <= 14'h0000;
      blockClk_q   <= 14'h0000;
      blockLines_q <= 4'h0;
      blMeas_q     <= 14'h0000;
      fieldLines_q <= 11'h000;
      vsLines_q    <= 5'h00;
      fieldClk_q   <= 21'h000000;
      prevLcf_q    <= 11'h000;
      prevLcvs_q   <= 5'h00;
      prevFcl_q    <= 13'h0000;
      intlMeas_q   <= video_standard_detector_pkg::RST_INTERLACE;
      hLock_q      <= 1'b0;
      hCnt_q       <= 8'h00;
      vLock_q      <= 1'b0;
      vCnt_q       <= 3'h0;
      sameCnt_q    <= 3'h0;
      blRd_q       <= 14'h0000;
      lcfRd_q      <= 11'h000;
      lcvsRd_q     <= 5'h00;
      fclRd_q      <= 13'h0000;
      intlRd_q     <= video_standard_detector_pkg::RST_INTERLACE;
      valid_q      <= video_standard_detector_pkg::RST_VALID;
    end
    else
    begin
      state_q      <= state_d;
      contMode_q   <= contMode_d;
      trigger_q    <= trigger_d;
      trigPrev_q   <= trigPrev_d;
      bypass_q     <= bypass_d;
      cfgIntl_q    <= cfgIntl_d;
      de_q         <= de_d;
      rdData_q     <= rdData_d;
      lineClk_q    <= lineClk_d;
      prevLine_q   <= prevLine_d;
      blockClk_q   <= blockClk_d;
      blockLines_q <= blockLines_d;
      blMeas_q     <= blMeas_d;
      fieldLines_q <= fieldLines_d;
      vsLines_q    <= vsLines_d;
      fieldClk_q   <= fieldClk_d;
      prevLcf_q    <= prevLcf_d;
      prevLcvs_q   <= prevLcvs_d;
      prevFcl_q    <= prevFcl_d;
      intlMeas_q   <= intlMeas_d;
      hLock_q      <= hLock_d;
      hCnt_q       <= hCnt_d;
      vLock_q      <= vLock_d;
      vCnt_q       <= vCnt_d;
      sameCnt_q    <= sameCnt_d;
      blRd_q       <= blRd_d;
      lcfRd_q      <= lcfRd_d;
      lcvsRd_q     <= lcvsRd_d;
      fclRd_q      <= fclRd_d;
      intlRd_q     <= intlRd_d;
      valid_q      <= valid_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdData   = rdData_q;
  assign processorDe = de_q;

endmodule

//--- tb/video_standard_detector_asserts.sv
// Concurrent checks on the detector register port and data enable path
`timescale 1ns/1ps
module video_standard_detector_asserts (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       receiverHsync,
  input wire logic       receiverVsync,
  input wire logic       receiverDe,
  input wire logic       configuredInterlace,
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       processorDe
);
  // ****************************************************************
  // Register port and data enable properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // One quiet cycle between write and read, as the bench tasks leave it
  sequence wrThenRd(logic [7:0] a);
    regWrEn && regAddr == a ##1 !regWrEn ##1 regRdEn && regAddr == a;
  endsequence
  sequence rdAt(logic [7:0] a);
    regRdEn && regAddr == a;
  endsequence
  AST_RD_HOLD: assert property (!regRdEn |=> $stable(regRdData)) else $error("read data moved");
  AST_RST_CLEAR: assert property (disable iff (1'b0) srst |=> regRdData == 8'h00 && !processorDe)
    else $error("reset values wrong");
  AST_DE_PASS: assert property (!$past(srst) |-> processorDe == $past(receiverDe))
    else $error("de path wrong");
  AST_UNMAPPED: assert property (regRdEn && !(regAddr inside {8'h12, 8'h86, 8'hA3, 8'hA4, 8'hB1,
    8'hB2, 8'hB3, 8'hB8, 8'hB9, 8'hF5}) |=> regRdData == 8'h00) else $error("unmapped read nonzero");
  AST_MODE_RW: assert property (wrThenRd(video_standard_detector_pkg::OFS_MODE_TRIGGER)
    |=> regRdData == ($past(regWrData, 3) & 8'h06)) else $error("mode write lost");
  AST_BYPASS_RW: assert property (wrThenRd(video_standard_detector_pkg::OFS_LOCK_BYPASS)
    |=> regRdData == ($past(regWrData, 3) & 8'h02)) else $error("bypass write lost");
  AST_MODE_RSVD: assert property (rdAt(8'h86) |=> regRdData[7:3] == 5'h00 && !regRdData[0])
    else $error("mode spare bits set");
  AST_CFG_INTLC: assert property (rdAt(8'h12) && configuredInterlace == $past(configuredInterlace, 3)
    |=> regRdData[3] == $past(configuredInterlace)) else $error("configured interlace wrong");
  AST_LCF_TOP: assert property (rdAt(8'hA3) |=> regRdData[7:3] == 5'h00) else $error("lcf width wrong");
  AST_FCL_TOP: assert property (rdAt(8'hB8) |=> regRdData[7:5] == 3'h0) else $error("fcl width wrong");
endmodule
bind video_standard_detector video_standard_detector_asserts chk (.clk(clk), .srst(srst),
  .receiverHsync(receiverHsync), .receiverVsync(receiverVsync), .receiverDe(receiverDe),
  .configuredInterlace(configuredInterlace), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .processorDe(processorDe));

//--- tb/video_sync_source.sv
// Receiver core model producing steady horizontal and vertical syncs
`timescale 1ns/1ps
module video_sync_source #(
  parameter int LINE_CLKS   = 20,
  parameter int FIELD_LINES = 40,
  parameter int VS_LINES    = 3
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      hsync,
  output logic      vsync
);
  int pixCnt;
  int lineCnt;
  // Counters step on the falling edge so sync edges never meet the sampling edge
  always @(negedge clk)
  begin
    if (srst || (pixCnt == LINE_CLKS - 1 && lineCnt == FIELD_LINES - 1))
    begin
      pixCnt = 0;
      lineCnt = 0;
    end
    else if (pixCnt == LINE_CLKS - 1)
    begin
      pixCnt = 0;
      lineCnt++;
    end
    else
      pixCnt++;
  end
  // Vsync edges sit two clocks after a line start, so it spans exactly VS_LINES hsync rises
  assign hsync = !srst && pixCnt < 4;
  assign vsync = !srst && ((lineCnt == 0 && pixCnt >= 2) || (lineCnt > 0 && lineCnt < VS_LINES)
    || (lineCnt == VS_LINES && pixCnt < 2));
endmodule

//--- tb/video_standard_detector_test.sv
// Register level testbench of the video standard detector
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failCount++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module video_standard_detector_test;
  logic       clk;
  logic       srst;
  logic       hs;
  logic       vs;
  logic       receiverDe;
  logic       configuredInterlace;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic       processorDe;
  logic [7:0] d;
  int         failCount;
  int         compares;
  int         cycles;
  // ****************************************************************
  // Clock, partner, design and timeout
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  video_sync_source src (.clk(clk), .srst(srst), .hsync(hs), .vsync(vs));
  video_standard_detector uut (.clk(clk), .srst(srst), .receiverHsync(hs), .receiverVsync(vs),
    .receiverDe(receiverDe), .configuredInterlace(configuredInterlace), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .processorDe(processorDe));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    {regAddr, regWrData, regWrEn} = {a, v, 1'b1};
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    {regAddr, regRdEn} = {a, 1'b1};
    @(negedge clk);
    regRdEn = 1'b0;
    v = regRdData;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask
  // Polling is bounded; lock takes up to five fields, the 128 lines for horizontal lock running alongside them
  task automatic waitValid;
    for (int i = 0; i < 600; i++)
    begin
      rd(8'hB1, d);
      if (d[7] === 1'b1)
        break;
      repeat (20) @(negedge clk);
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failCount++;
      wrap_up;
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    {srst, receiverDe, configuredInterlace, regAddr, regWrEn, regWrData, regRdEn} = {1'b1, 20'h00000};
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rdChk(8'h86, 8'h02);
    rdChk(8'hF5, 8'h00);
    rdChk(8'hB1, 8'h00);
    rdChk(8'h12, 8'h00);
    rdChk(8'h55, 8'h00);
    receiverDe = 1'b1;
    @(negedge clk);
    `CHK(processorDe, 1'b1)
    receiverDe = 1'b0;
    @(negedge clk);
    `CHK(processorDe, 1'b0)
    waitValid;
    rdChk(8'hB1, 8'h80);
    rdChk(8'hA3, 8'h00);
    rdChk(8'hA4, 8'h28);
    rdChk(8'hB3, 8'h18);
    rdChk(8'hB8, 8'h00);
    rdChk(8'hB9, 8'h03);
    rdChk(8'h12, 8'h00);
    rdChk(8'hB2, 8'hA0);
    configuredInterlace = 1'b1;
    repeat (4) @(negedge clk);
    rdChk(8'h12, 8'h08);
    wr(8'hB1, 8'hFF);
    rdChk(8'hB1, 8'h80);
    wr(8'h86, 8'h00);
    wr(8'h86, 8'h04);
    rd(8'hB1, d);
    `CHK(d[7], 1'b0)
    waitValid;
    rdChk(8'h86, 8'h04);
    wr(8'h86, 8'h00);
    rdChk(8'hB1, 8'h80);
    rdChk(8'hA4, 8'h28);
    wr(8'hF5, 8'h02);
    rdChk(8'hF5, 8'h02);
    wr(8'h86, 8'h02);
    rdChk(8'h86, 8'h02);
    repeat (1700) @(negedge clk);
    rdChk(8'hA4, 8'h28);
    wrap_up;
  end
endmodule
